// File: common/flash_seq_pkg.sv
// Constants for the flash special-area command sequencer
package flash_seq_pkg;
    // Register offsets (byte addresses)
    localparam logic [3:0] MODE_OFFSET    = 4'h0;
    localparam logic [3:0] CMD_OFFSET     = 4'h4;
    localparam logic [3:0] STATUS_OFFSET  = 4'h8;
    localparam logic [3:0] RESULT_OFFSET  = 4'hC;
    localparam logic [3:0] CONTROL_OFFSET = 4'h0;
    // Mode register fields
    localparam int         MODE_RDY_IE_BIT = 0;
    localparam logic [31:0] MODE_RESET     = 32'h0400_0000;
    localparam logic [31:0] MODE_WMASK     = 32'h0501_0F01;
    // Command register fields
    localparam int         KEY_LSB   = 24;
    localparam int         ARG_LSB   = 8;
    localparam logic [7:0] KEY_VALUE = 8'h5A;
    // Status register bits
    localparam int         STAT_READY_BIT = 0;
    localparam int         STAT_CMDERR_BIT = 1;
    localparam int         STAT_FLASHERR_BIT = 3;
    // Command codes
    localparam logic [7:0] set_option_bit_cmd        = 8'h0B;
    localparam logic [7:0] clear_option_bit_cmd      = 8'h0C;
    localparam logic [7:0] get_option_bits_cmd       = 8'h0D;
    localparam logic [7:0] start_read_identifier_cmd = 8'h0E;
    localparam logic [7:0] stop_read_identifier_cmd  = 8'h0F;
    localparam logic [7:0] get_calibration_bits_cmd  = 8'h10;
    localparam logic [7:0] write_signature_cmd       = 8'h12;
    localparam logic [7:0] erase_signature_cmd       = 8'h13;
    localparam logic [7:0] start_read_signature_cmd  = 8'h14;
    localparam logic [7:0] stop_read_signature_cmd   = 8'h15;
    // Option bits
    localparam int          OPT_BITS        = 2;
    localparam logic [15:0] OPT_ERR_LIMIT   = 16'h0008;
    localparam int          SECURITY_BIT    = 0;
    // Calibration stream
    localparam int          CAL_WORDS       = 2;
    localparam int          CAL8_LSB        = 22;
    localparam int          CAL4_LSB        = 32;
    localparam logic [6:0]  CAL12_VALUE     = 7'h40;
    // Special area windows, byte addresses
    localparam logic [31:0] AREA_BASE       = 32'h0040_0000;
    localparam logic [31:0] ID_LAST         = 32'h0040_03FF;
    localparam logic [31:0] SIG_LAST        = 32'h0040_01FF;
    localparam int          SIG_WORDS       = 128;
    // Time given to one nonvolatile operation
    localparam int          OP_TIME_NS      = 100;
    localparam int          CLK_PERIOD_NS   = 5;
    localparam logic [7:0]  OP_CYCLES       = 8'(OP_TIME_NS / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_OPTION, SEQ_SIG_WRITE, SEQ_SIG_ERASE, SEQ_AREA_READ
    } seq_state_type;

    typedef enum logic [1:0] {
        STREAM_NONE, STREAM_OPTION, STREAM_CAL
    } stream_type;
endpackage

// File: rtl/flash_special_area_sequencer.sv
// Flash special-area command sequencer: option bits, calibration, signature
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps

module flash_special_area_sequencer
    import flash_seq_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        fetch_read,
    input  wire logic [31:0] array_rdata,
    output logic      [31:0] fetch_rdata,
    input  wire logic [31:0] latch_data,
    output logic      [6:0]  latch_index,
    input  wire logic [6:0]  cal8_trim,
    input  wire logic [6:0]  cal4_trim,
    input  wire logic [31:0] identifier_word,
    output logic      [7:0]  identifier_index,
    input  wire logic        verify_fail,
    input  wire logic        erase_pin,
    input  wire logic        full_erase_done,
    output logic             security_on,
    output logic             debug_access_block,
    output logic             ready_irq,
    output logic             area_mapped
);

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    logic [31:0]         mode_r;
    logic                ready_r;
    logic                cmd_err_r;
    logic                flash_err_r;
    logic [OPT_BITS-1:0] opt_r;
    logic [31:0]         sig_r [SIG_WORDS];
    seq_state_type       state_r;
    logic [7:0]          cmd_r;
    logic [15:0]         arg_r;
    logic [7:0]          timer_r;
    logic [6:0]          word_r;
    stream_type          stream_r;
    logic [1:0]          result_idx_r;
    logic                id_mode_r;
    logic                ready_prev_r;
    logic [31:0]         reg_rdata_r;
    logic [31:0]         fetch_rdata_r;

    wire cmd_write = reg_write && reg_addr == CMD_OFFSET;
    wire [7:0]  wr_key = reg_wdata[KEY_LSB +: 8];
    wire [7:0]  wr_cmd = reg_wdata[7:0];
    wire [15:0] wr_arg = reg_wdata[ARG_LSB +: 16];
    wire key_ok = wr_key == KEY_VALUE;
    wire op_done = timer_r == 8'h00;

    function automatic logic known_cmd(input logic [7:0] c);
        known_cmd = c == set_option_bit_cmd || c == clear_option_bit_cmd ||
                    c == get_option_bits_cmd ||
                    c == get_calibration_bits_cmd ||
                    c == start_read_identifier_cmd ||
                    c == stop_read_identifier_cmd ||
                    c == start_read_signature_cmd ||
                    c == stop_read_signature_cmd ||
                    c == write_signature_cmd || c == erase_signature_cmd;
    endfunction

    function automatic logic is_option_cmd(input logic [7:0] c);
        is_option_cmd = c == set_option_bit_cmd || c == clear_option_bit_cmd;
    endfunction

    // Commands accepted only when idle or in a special-area read; busy writes are dropped
    // Key check gate
    wire accept = cmd_write && key_ok && known_cmd(wr_cmd) &&
                  (state_r == SEQ_IDLE || state_r == SEQ_AREA_READ);
    wire opt_too_high = wr_arg > OPT_ERR_LIMIT;

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            mode_r <= MODE_RESET;
        else if (reg_write && reg_addr == MODE_OFFSET)
            mode_r <= reg_wdata & MODE_WMASK;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            state_r <= SEQ_IDLE;
            cmd_r   <= 8'h00;
            arg_r   <= 16'h0000;
            timer_r <= 8'h00;
            word_r  <= 7'h00;
            id_mode_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                SEQ_IDLE, SEQ_AREA_READ:
                begin
                    if (accept)
                    begin
                        cmd_r   <= wr_cmd;
                        arg_r   <= wr_arg;
                        timer_r <= OP_CYCLES;
                        word_r  <= 7'h00;
                        if (is_option_cmd(wr_cmd))
                            state_r <= SEQ_OPTION;
                        else if (wr_cmd == write_signature_cmd)
                            state_r <= SEQ_SIG_WRITE;
                        else if (wr_cmd == erase_signature_cmd)
                            state_r <= SEQ_SIG_ERASE;
                        else if (wr_cmd == start_read_identifier_cmd)
                        begin
                            state_r   <= SEQ_AREA_READ;
                            id_mode_r <= 1'b1;
                        end
                        else if (wr_cmd == start_read_signature_cmd)
                        begin
                            state_r   <= SEQ_AREA_READ;
                            id_mode_r <= 1'b0;
                        end
                        else if (wr_cmd == stop_read_identifier_cmd ||
                                 wr_cmd == stop_read_signature_cmd)
                            state_r <= SEQ_IDLE;
                    end
                end
                SEQ_OPTION, SEQ_SIG_ERASE:
                begin
                    timer_r <= timer_r - 8'h01;
                    if (op_done)
                        state_r <= SEQ_IDLE;
                end
                SEQ_SIG_WRITE:
                begin
                    // One latch word per cycle; whole page copied
                    word_r <= word_r + 7'h01;
                    if (word_r == 7'(SIG_WORDS - 1))
                        state_r <= SEQ_IDLE;
                end
            endcase
        end
    end

    assign latch_index = word_r;

    // ------------------------------------------------------------
    // Option bits and security
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            opt_r <= '0;
        else if (state_r == SEQ_OPTION && op_done &&
                 arg_r < 16'(OPT_BITS))
        begin
            if (cmd_r == set_option_bit_cmd && arg_r != 16'(SECURITY_BIT))
                opt_r[arg_r[0]] <= 1'b1;
            else if (cmd_r == set_option_bit_cmd)
                opt_r[SECURITY_BIT] <= 1'b1;
            // Clear option bit; security needs the erase pin
            else if (arg_r != 16'(SECURITY_BIT))
                opt_r[arg_r[0]] <= 1'b0;
        end
        else if (erase_pin && full_erase_done)
            opt_r[SECURITY_BIT] <= 1'b0;
    end

    assign security_on = opt_r[SECURITY_BIT];
    assign debug_access_block = opt_r[SECURITY_BIT];

    // ------------------------------------------------------------
    // Signature storage
    // ------------------------------------------------------------
    // Signature area
    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < SIG_WORDS; i++)
        begin
            if (state_r == SEQ_SIG_ERASE && op_done)
                sig_r[i] <= 32'hFFFF_FFFF;
            else if (state_r == SEQ_SIG_WRITE && word_r == 7'(i))
                sig_r[i] <= latch_data;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    wire finishing = (state_r == SEQ_OPTION || state_r == SEQ_SIG_ERASE) &&
                     op_done ||
                     state_r == SEQ_SIG_WRITE &&
                     word_r == 7'(SIG_WORDS - 1);

    // Status read clears error flags; a new event wins over the clear
    wire status_read = reg_read && reg_addr == STATUS_OFFSET;
    wire cmd_err_set = cmd_write &&
                       (!key_ok || (key_ok && is_option_cmd(wr_cmd) &&
                        opt_too_high));
    wire flash_err_set = finishing && verify_fail;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            cmd_err_r <= 1'b0;
        else if (cmd_err_set)
            cmd_err_r <= 1'b1;
        else if (status_read)
            cmd_err_r <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            flash_err_r <= 1'b0;
        else if (flash_err_set)
            flash_err_r <= 1'b1;
        else if (status_read)
            flash_err_r <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            ready_r <= 1'b1;
        else if (accept && !(wr_cmd == stop_read_identifier_cmd ||
                              wr_cmd == stop_read_signature_cmd ||
                              wr_cmd == get_option_bits_cmd ||
                              wr_cmd == get_calibration_bits_cmd))
            ready_r <= 1'b0;
        else if (accept)
            ready_r <= 1'b1;
        else if (finishing)
            ready_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // Ready interrupt
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            ready_prev_r <= 1'b1;
        else
            ready_prev_r <= ready_r;
    end

    assign ready_irq = mode_r[MODE_RDY_IE_BIT] && ready_r && !ready_prev_r;

    // ------------------------------------------------------------
    // Result stream
    // ------------------------------------------------------------
    wire result_read = reg_read && reg_addr == RESULT_OFFSET;
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            stream_r     <= STREAM_NONE;
            result_idx_r <= 2'b00;
        end
        else if (accept && wr_cmd == get_option_bits_cmd)
        begin
            stream_r     <= STREAM_OPTION;
            result_idx_r <= 2'b00;
        end
        else if (accept && wr_cmd == get_calibration_bits_cmd)
        begin
            stream_r     <= STREAM_CAL;
            result_idx_r <= 2'b00;
        end
        else if (result_read && result_idx_r != 2'b11)
            result_idx_r <= result_idx_r + 2'b01;
    end

    // 12 MHz pattern fixed, no stored value
    // Calibration inputs only, no write path
    wire [63:0] cal_stream = (64'(cal8_trim) << CAL8_LSB) |
                             (64'(cal4_trim) << CAL4_LSB) |
                             (64'(CAL12_VALUE) << (CAL4_LSB + 8));

    logic [31:0] result_word;
    always_comb
    begin
        result_word = 32'h0000_0000;
        unique case (stream_r)
            STREAM_NONE:
                result_word = 32'h0000_0000;
            STREAM_OPTION:
                if (result_idx_r == 2'b00)
                    result_word = 32'(opt_r);
            STREAM_CAL:
                if (result_idx_r < 2'(CAL_WORDS))
                    result_word = cal_stream[result_idx_r[0]*32 +: 32];
        endcase
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            reg_rdata_r <= 32'h0000_0000;
        else if (reg_read)
        begin
            unique case (reg_addr)
                MODE_OFFSET:   reg_rdata_r <= mode_r;
                STATUS_OFFSET: reg_rdata_r <= {28'h0000000, flash_err_r,
                                               1'b0, cmd_err_r, ready_r};
                RESULT_OFFSET: reg_rdata_r <= result_word;
                default:       reg_rdata_r <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata_r <= 32'h0000_0000;
    end
    assign reg_rdata = reg_rdata_r;

    // ------------------------------------------------------------
    // Flash read path
    // ------------------------------------------------------------
    // Processor fetch kept off flash by software meanwhile
    wire in_window = fetch_addr >= AREA_BASE &&
                     fetch_addr <= (id_mode_r ? ID_LAST : SIG_LAST);
    assign area_mapped = state_r == SEQ_AREA_READ;
    assign identifier_index = fetch_addr[9:2];

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            fetch_rdata_r <= 32'h0000_0000;
        else if (fetch_read)
        begin
            if (area_mapped && in_window && id_mode_r)
                fetch_rdata_r <= identifier_word;
            else if (area_mapped && in_window)
                fetch_rdata_r <= sig_r[fetch_addr[8:2]];
            else
                fetch_rdata_r <= array_rdata;
        end
    end
    assign fetch_rdata = fetch_rdata_r;

endmodule

// File: verif/flash_array_model.sv
// Behavioural flash array, latch buffer, identifier and trim store
`timescale 1ns/100ps
module flash_array_model
#(
    parameter logic [6:0] CAL8_VAL = 7'h2B,
    parameter logic [6:0] CAL4_VAL = 7'h15
)
(
    input  wire logic [31:0] fetch_addr,
    input  wire logic [6:0]  latch_index,
    input  wire logic [7:0]  identifier_index,
    output logic      [31:0] array_rdata,
    output logic      [31:0] latch_data,
    output logic      [31:0] identifier_word,
    output logic      [6:0]  cal8_trim,
    output logic      [6:0]  cal4_trim
);
    // Address-dependent data so a stale word never passes
    assign array_rdata = ~fetch_addr;
    assign latch_data = 32'h5100_0000 | 32'(latch_index);
    assign identifier_word = 32'h1D00_0000 | 32'(identifier_index);
    assign cal8_trim = CAL8_VAL;
    assign cal4_trim = CAL4_VAL;
endmodule

// File: verif/flash_seq_properties.sv
// Port-level assertions for the flash special-area sequencer
`timescale 1ns/100ps
module flash_seq_properties
    import flash_seq_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        fetch_read,
    input wire logic [31:0] array_rdata,
    input wire logic [31:0] fetch_rdata,
    input wire logic        erase_pin,
    input wire logic        full_erase_done,
    input wire logic        security_on,
    input wire logic        debug_access_block,
    input wire logic        ready_irq,
    input wire logic        area_mapped
);
    // ----------------------------------------------------------------
    // Helper state
    // ----------------------------------------------------------------
    logic        cmd_ok;
    logic        opt_go;
    logic [7:0]  code;
    logic        ie_r;
    logic [7:0]  busy_r;

    assign code   = reg_wdata[7:0];
    assign cmd_ok = reg_write && reg_addr == CMD_OFFSET
                    && reg_wdata[31:24] == KEY_VALUE && busy_r == 8'h00;
    assign opt_go = cmd_ok && !area_mapped && (code == set_option_bit_cmd
                    || code == clear_option_bit_cmd
                    || code == erase_signature_cmd);

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            ie_r <= 1'b0;
        else if (reg_write && reg_addr == MODE_OFFSET)
            ie_r <= reg_wdata[MODE_RDY_IE_BIT];
    end

    // Busy window so dropped commands are not taken for starts
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            busy_r <= 8'h00;
        else if (cmd_ok && !area_mapped && code == write_signature_cmd)
            busy_r <= 8'h81;
        else if (opt_go)
            busy_r <= 8'h16;
        else if (busy_r != 8'h00)
            busy_r <= busy_r - 8'h01;
    end

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sec_block_a: assert property (
        debug_access_block == security_on)
        else $error("debug block not security");
    sec_clear_a: assert property (
        $fell(security_on) |-> $past(erase_pin && full_erase_done))
        else $error("security cleared without erase");
    irq_pulse_a: assert property (
        ready_irq |=> !ready_irq)
        else $error("ready interrupt too long");
    irq_enable_a: assert property (
        ready_irq |-> ie_r)
        else $error("ready interrupt while enable is off");
    opt_done_a: assert property (
        opt_go && ie_r |=> !ready_irq [*8] ##14 ready_irq)
        else $error("option or erase end mistimed");
    sig_done_a: assert property (
        cmd_ok && !area_mapped && ie_r && code == write_signature_cmd
        |-> ##129 ready_irq)
        else $error("signature write end mistimed");
    map_start_a: assert property (
        cmd_ok && !area_mapped && (code == start_read_identifier_cmd
        || code == start_read_signature_cmd) |=> area_mapped)
        else $error("special area not mapped after start");
    map_stop_a: assert property (
        cmd_ok && area_mapped && ie_r && (code == stop_read_identifier_cmd
        || code == stop_read_signature_cmd)
        |-> ##[1:3] (ready_irq && !area_mapped))
        else $error("stop did not unmap and raise ready");
    fetch_resp_a: assert property (
        fetch_read && !area_mapped |=> fetch_rdata == $past(array_rdata))
        else $error("array read not served");
endmodule

// File: verif/flash_special_area_sequencer_test.sv
// Self-checking bench for the flash special-area sequencer
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    bad_count++; $display("unexpected t=%0t got %h exp %h", \
    $time, (got), (exp)); end end
module flash_special_area_sequencer_test
    import flash_seq_pkg::*;
;
    localparam logic [6:0]  CAL8 = 7'h2B;
    localparam logic [6:0]  CAL4 = 7'h15;
    localparam logic [31:0] OG   = 32'h5A00_000D;
    localparam logic [31:0] GC   = 32'h5A00_3310;
    localparam logic [31:0] C0   = 32'(CAL8) << CAL8_LSB;
    localparam logic [31:0] C1   = (32'(CAL12_VALUE) << 8) | 32'(CAL4);
    logic        core_clk, reset_n, reg_write, reg_read, fetch_read;
    logic        verify_fail, erase_pin, full_erase_done, security_on;
    logic        debug_access_block, ready_irq, area_mapped, seen;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, fetch_addr, array_rdata;
    logic [31:0] fetch_rdata, latch_data, identifier_word, rd_val;
    logic [6:0]  latch_index, cal8_trim, cal4_trim;
    logic [7:0]  identifier_index;
    int          bad_count = 0;
    int          compares = 0;
    int          cycles = 0;
    typedef struct packed {
        logic [31:0] cmd; logic vf; logic op; logic [31:0] st, get, r0, r1;
    } row_type;
    // Command, verify fail, completes, status, get command, result words
    row_type rows [14] = '{
        '{32'h5A00_010B, 1'b0, 1'b1, 32'h1, OG, 32'h2, 32'h0},
        '{32'h5A00_000B, 1'b0, 1'b1, 32'h1, OG, 32'h3, 32'h0},
        '{32'h5A00_010B, 1'b1, 1'b1, 32'h9, OG, 32'h3, 32'h0},
        '{32'h5A00_010C, 1'b0, 1'b1, 32'h1, OG, 32'h1, 32'h0},
        '{32'h5A00_080B, 1'b0, 1'b1, 32'h1, OG, 32'h1, 32'h0},
        '{32'h5A00_090B, 1'b0, 1'b1, 32'h3, OG, 32'h1, 32'h0},
        '{32'h5A00_090C, 1'b0, 1'b1, 32'h3, OG, 32'h1, 32'h0},
        '{32'h5B00_010B, 1'b0, 1'b0, 32'h3, OG, 32'h1, 32'h0},
        '{32'h5A00_FF0D, 1'b0, 1'b0, 32'h1, 32'h5A00_770D, 32'h1, 32'h0},
        '{32'h5A00_0010, 1'b0, 1'b0, 32'h1, GC, C0, C1},
        '{32'h5A00_0013, 1'b1, 1'b1, 32'h9, OG, 32'h1, 32'h0},
        '{32'h5A00_0013, 1'b0, 1'b1, 32'h1, OG, 32'h1, 32'h0},
        '{32'h5A00_0012, 1'b1, 1'b1, 32'h9, OG, 32'h1, 32'h0},
        '{32'h5A00_0012, 1'b0, 1'b1, 32'h1, OG, 32'h1, 32'h0}};

    flash_special_area_sequencer dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .fetch_addr(fetch_addr),
        .fetch_read(fetch_read), .array_rdata(array_rdata),
        .fetch_rdata(fetch_rdata), .latch_data(latch_data),
        .latch_index(latch_index), .cal8_trim(cal8_trim),
        .cal4_trim(cal4_trim), .identifier_word(identifier_word),
        .identifier_index(identifier_index), .verify_fail(verify_fail),
        .erase_pin(erase_pin), .full_erase_done(full_erase_done),
        .security_on(security_on), .debug_access_block(debug_access_block),
        .ready_irq(ready_irq), .area_mapped(area_mapped));
    flash_array_model #(.CAL8_VAL(CAL8), .CAL4_VAL(CAL4)) model_u (
        .fetch_addr(fetch_addr), .latch_index(latch_index),
        .identifier_index(identifier_index), .array_rdata(array_rdata),
        .latch_data(latch_data), .identifier_word(identifier_word),
        .cal8_trim(cal8_trim), .cal4_trim(cal4_trim));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic fetch(input logic [31:0] a, input logic [31:0] e);
        @(posedge core_clk);
        fetch_addr <= a;
        fetch_read <= 1'b1;
        @(posedge core_clk);
        fetch_read <= 1'b0;
        #1;
        `CHK(fetch_rdata, e)
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        #1;
        while (ready_irq !== 1'b1 && n < 300)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK(n < 300, 1'b1)
    endtask

    // Start a special read, check one word, stop and check the array again
    task automatic area_check(input logic [31:0] c, input logic [31:0] a,
                              input logic [31:0] e);
        logic [31:0] s;
        wr(CMD_OFFSET, c);
        @(posedge core_clk);
        #1;
        `CHK(area_mapped, 1'b1)
        rd(STATUS_OFFSET, s);
        `CHK(s, 32'h0)
        fetch(a, e);
        wr(CMD_OFFSET, c + 32'h1);
        wait_irq();
        `CHK(area_mapped, 1'b0)
        fetch(a, ~a);
    endtask

    initial
    begin
        {reg_write, reg_read, fetch_read, verify_fail} = 4'h0;
        {erase_pin, full_erase_done, reset_n, reg_addr} = 7'h00;
        {reg_wdata, fetch_addr} = 64'h0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(STATUS_OFFSET, rd_val);
        `CHK(rd_val, 32'h0000_0001)
        rd(MODE_OFFSET, rd_val);
        `CHK(rd_val, MODE_RESET)
        rd(RESULT_OFFSET, rd_val);
        `CHK(rd_val, 32'h0)
        `CHK(security_on, 1'b0)
        // Interrupt disabled: no pulse, array reads still served
        wr(CMD_OFFSET, 32'h5A00_010B);
        fetch(32'h0000_0100, ~32'h0000_0100);
        seen = 1'b0;
        repeat (40)
        begin
            @(posedge core_clk);
            #1;
            seen = seen | ready_irq;
        end
        `CHK(seen, 1'b0)
        rd(STATUS_OFFSET, rd_val);
        `CHK(rd_val, 32'h1)
        wr(MODE_OFFSET, 32'h0400_0001);
        rd(MODE_OFFSET, rd_val);
        `CHK(rd_val, 32'h0400_0001)
        foreach (rows[i])
        begin
            verify_fail <= rows[i].vf;
            wr(CMD_OFFSET, rows[i].cmd);
            if (rows[i].op)
                wait_irq();
            else
                repeat (2) @(posedge core_clk);
            verify_fail <= 1'b0;
            rd(STATUS_OFFSET, rd_val);
            `CHK(rd_val, rows[i].st)
            wr(CMD_OFFSET, rows[i].get);
            rd(RESULT_OFFSET, rd_val);
            `CHK(rd_val, rows[i].r0)
            rd(RESULT_OFFSET, rd_val);
            `CHK(rd_val, rows[i].r1)
            rd(RESULT_OFFSET, rd_val);
            `CHK(rd_val, 32'h0)
        end
        `CHK(security_on, 1'b1)
        `CHK(debug_access_block, 1'b1)
        erase_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(security_on, 1'b1)
        full_erase_done <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(security_on, 1'b0)
        `CHK(debug_access_block, 1'b0)
        erase_pin <= 1'b0;
        full_erase_done <= 1'b0;
        // data reads only during special reads
        area_check(32'h5A00_000E, AREA_BASE + 32'h8, 32'h1D00_0002);
        area_check(32'h5A00_000E, ID_LAST, 32'h1D00_00FF);
        area_check(32'h5A00_0014, AREA_BASE, 32'h5100_0000);
        area_check(32'h5A00_0014, SIG_LAST, 32'h5100_007F);
        wr(CMD_OFFSET, 32'h5A00_0013);
        wait_irq();
        area_check(32'h5A00_0014, AREA_BASE + 32'h4, 32'hFFFF_FFFF);
        give_verdict();
    end
endmodule

bind flash_special_area_sequencer flash_seq_properties chk_u (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .fetch_read(fetch_read),
    .array_rdata(array_rdata), .fetch_rdata(fetch_rdata),
    .erase_pin(erase_pin), .full_erase_done(full_erase_done),
    .security_on(security_on), .debug_access_block(debug_access_block),
    .ready_irq(ready_irq), .area_mapped(area_mapped));
